/* File: boundary_scan_defines.svh */
`ifndef BOUNDARY_SCAN_DEFINES_SVH
`define BOUNDARY_SCAN_DEFINES_SVH

// ****************************************************************
// Pin groups
// ****************************************************************
`define BSC_LANES 6
`define BSC_BIDIR 11
`define BSC_MGMT_PINS 4

// ****************************************************************
// Chain ordering table, cell 0 sits next to the serial output
// ****************************************************************
`define BSC_RX_NEG_BASE 0
`define BSC_RX_POS_BASE 6
`define BSC_DS_STRAP_CELL 12
`define BSC_US_STRAP_CELL 13
`define BSC_FUND_RESET_CELL 14
`define BSC_TX_CTL_BASE 15
`define BSC_BIDIR_BASE 21
`define BSC_LEN 43

// ****************************************************************
// Instruction codes
// ****************************************************************
`define IR_WIDTH 6
`define IR_EXTEST 6'h00
`define IR_SAMPLE 6'h01
`define IR_IDCODE 6'h02
`define IR_HIGHZ 6'h03
`define IR_CAPTURE 6'h2D
`define IR_CLAMP 6'h3E
`define IR_BYPASS 6'h3F
`define ID_WIDTH 32

`endif

/* File: boundary_scan_pkg.sv */
`include "boundary_scan_defines.svh"

package boundary_scan_pkg;

    // ****************************************************************
    // Controller states
    // ****************************************************************
    typedef enum logic [3:0] {
        TEST_RESET = 4'h0,
        RUN_IDLE = 4'h1,
        SELECT_DR = 4'h2,
        CAPTURE_DR = 4'h3,
        SHIFT_DR = 4'h4,
        EXIT1_DR = 4'h5,
        PAUSE_DR = 4'h6,
        EXIT2_DR = 4'h7,
        UPDATE_DR = 4'h8,
        SELECT_IR = 4'h9,
        CAPTURE_IR = 4'hA,
        SHIFT_IR = 4'hB,
        EXIT1_IR = 4'hC,
        PAUSE_IR = 4'hD,
        EXIT2_IR = 4'hE,
        UPDATE_IR = 4'hF
    } tap_state_type;

    // ****************************************************************
    // Pin groups
    // ****************************************************************
    typedef struct packed {
        logic [`BSC_LANES-1:0] laneReceiveNegative;
        logic [`BSC_LANES-1:0] laneReceivePositive;
        logic downstreamCommonClockStrap;
        logic upstreamCommonClockStrap;
        logic fundamentalResetN;
        logic [`BSC_BIDIR-1:0] bidirIn;
    } pad_in_type;

    typedef struct packed {
        logic [`BSC_LANES-1:0] laneTransmitEnable;
        logic [`BSC_BIDIR-1:0] bidirOut;
        logic [`BSC_BIDIR-1:0] bidirOutEnable;
    } core_out_type;

    typedef struct packed {
        logic [`BSC_LANES-1:0] laneTransmitEnable;
        logic [`BSC_BIDIR-1:0] bidirOut;
        logic [`BSC_BIDIR-1:0] bidirOeN;
    } pad_out_type;

    // ****************************************************************
    // Whole module state
    // ****************************************************************
    typedef struct packed {
        logic tckMeta;
        logic tckSync;
        logic tckPrev;
        logic tmsMeta;
        logic tmsSync;
        logic tdiMeta;
        logic tdiSync;
        logic trstMeta;
        logic trstSync;
        pad_in_type padMeta;
        pad_in_type padSync;
        tap_state_type tap;
        logic [`IR_WIDTH-1:0] irShift;
        logic [`IR_WIDTH-1:0] irCur;
        logic bypass;
        logic [`ID_WIDTH-1:0] idShift;
        logic [`BSC_LEN-1:0] bsShift;
        logic [`BSC_LEN-1:0] bsLatch;
        logic tdo;
        logic tdoOeN;
        pad_out_type pads;
    } state_type;

endpackage

/* File: boundary_scan_data_registers.sv */
`timescale 1ns/1ps
`include "boundary_scan_defines.svh"

module boundary_scan_data_registers
    import boundary_scan_pkg::*;
#(
    parameter logic [`ID_WIDTH-1:0] ID_VALUE = 32'h0000_0001 // Arbitrary value, bit 0 kept high
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic testResetN,
    output logic tdo,
    output logic tdoOeN,
    // System pins
    input wire pad_in_type padIn,
    input wire core_out_type coreOut,
    output pad_out_type padOut
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (`BSC_LANES < 1 || `BSC_BIDIR < 1) begin : gen_size_check
        $error("Pin groups must not be empty");
    end
    if (`IR_WIDTH < 2) begin : gen_ir_check
        $error("Instruction register too short for the capture pattern");
    end

    // Ordering table must be gap free and end at the chain length
    if (`BSC_RX_NEG_BASE != 0) begin : gen_first_check
        $error("Chain must start next to the serial output");
    end
    if (`BSC_RX_POS_BASE != `BSC_RX_NEG_BASE + `BSC_LANES) begin : gen_rx_check
        $error("Receive cells overlap or leave a gap");
    end
    if (`BSC_DS_STRAP_CELL != `BSC_RX_POS_BASE + `BSC_LANES) begin : gen_ds_check
        $error("Downstream strap cell misplaced");
    end
    if (`BSC_US_STRAP_CELL != `BSC_DS_STRAP_CELL + 1) begin : gen_us_check
        $error("Upstream strap cell misplaced");
    end
    if (`BSC_FUND_RESET_CELL != `BSC_US_STRAP_CELL + 1) begin : gen_fund_check
        $error("Fundamental reset cell misplaced");
    end
    if (`BSC_TX_CTL_BASE != `BSC_FUND_RESET_CELL + 1) begin : gen_ctl_check
        $error("Transmit control cells misplaced");
    end
    if (`BSC_TX_CTL_BASE + `BSC_LANES != `BSC_BIDIR_BASE) begin : gen_tx_check
        $error("Transmit control cells overlap bidirectional cells");
    end
    if (`BSC_BIDIR_BASE + 2 * `BSC_BIDIR != `BSC_LEN) begin : gen_len_check
        $error("Boundary chain length does not match ordering table");
    end

    // Codes the serial protocol fixes
    if (ID_VALUE[0] != 1'b1) begin : gen_id_check
        $error("Identification value must end in a one");
    end
    if (`ID_WIDTH != 32) begin : gen_idw_check
        $error("Identification register must be 32 bits");
    end
    if (((`IR_CAPTURE) & 6'h03) != 6'h01) begin : gen_capture_check
        $error("Instruction capture pattern must end in 01");
    end
    if (`IR_BYPASS != {`IR_WIDTH{1'b1}}) begin : gen_bypass_check
        $error("Bypass code must be all ones");
    end
    if (`IR_EXTEST == `IR_SAMPLE) begin : gen_code_check
        $error("Boundary instructions share a code");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic tap_state_type tapNext(input tap_state_type st, input logic m);
        tap_state_type r;
        r = st;
        unique case (st)
            TEST_RESET: r = m ? TEST_RESET : RUN_IDLE;
            RUN_IDLE: r = m ? SELECT_DR : RUN_IDLE;
            SELECT_DR: r = m ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: r = m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: r = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: r = m ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: r = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: r = m ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: r = m ? SELECT_DR : RUN_IDLE;
            SELECT_IR: r = m ? TEST_RESET : CAPTURE_IR;
            CAPTURE_IR: r = m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: r = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: r = m ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: r = m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: r = m ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: r = m ? SELECT_DR : RUN_IDLE;
        endcase
        return r;
    endfunction

    function automatic logic chainSelected(input logic [`IR_WIDTH-1:0] ir);
        return (ir == `IR_EXTEST) || (ir == `IR_SAMPLE);
    endfunction

    function automatic logic extestActive(input logic [`IR_WIDTH-1:0] ir);
        return ir == `IR_EXTEST;
    endfunction

    function automatic logic latchDrivesPins(input logic [`IR_WIDTH-1:0] ir);
        return (ir == `IR_EXTEST) || (ir == `IR_CLAMP);
    endfunction

    function automatic logic pinsFloat(input logic [`IR_WIDTH-1:0] ir);
        return ir == `IR_HIGHZ;
    endfunction

    // Parallel capture values in ordering-table positions
    function automatic logic [`BSC_LEN-1:0] captureChain(
        input pad_in_type pin,
        input core_out_type core,
        input logic extest
    );
        logic [`BSC_LEN-1:0] c;
        c = '0;
        for (int k = 0; k < `BSC_LANES; k++) begin
            c[`BSC_RX_NEG_BASE + k] = pin.laneReceiveNegative[k];
            c[`BSC_RX_POS_BASE + k] = pin.laneReceivePositive[k];
            c[`BSC_TX_CTL_BASE + k] = core.laneTransmitEnable[k];
        end
        c[`BSC_DS_STRAP_CELL] = pin.downstreamCommonClockStrap;
        c[`BSC_US_STRAP_CELL] = pin.upstreamCommonClockStrap;
        c[`BSC_FUND_RESET_CELL] = pin.fundamentalResetN;
        for (int k = 0; k < `BSC_BIDIR; k++) begin
            c[`BSC_BIDIR_BASE + 2 * k] = core.bidirOutEnable[k];
            // Core data only while the pad really drives outward
            if (!extest && core.bidirOutEnable[k]) begin
                c[`BSC_BIDIR_BASE + 2 * k + 1] = core.bidirOut[k];
            end else begin
                c[`BSC_BIDIR_BASE + 2 * k + 1] = pin.bidirIn[k];
            end
        end
        return c;
    endfunction

    function automatic state_type resetState();
        state_type r;
        r = '0;
        r.tap = TEST_RESET;
        r.irCur = `IR_IDCODE;
        r.tdoOeN = 1'b1;
        r.pads.bidirOeN = '1;
        return r;
    endfunction

    localparam state_type STATE_RESET = resetState();

    // ****************************************************************
    // State
    // ****************************************************************
    state_type s_reg;
    state_type s_next;

    always_comb begin
        logic tckRise;
        logic tckFall;
        logic drBit;
        logic pinsFromLatch;
        tckRise = 1'b0;
        tckFall = 1'b0;
        drBit = 1'b0;
        pinsFromLatch = 1'b0;
        s_next = s_reg;

        // Pins pass two flip-flops before any use
        s_next.tckMeta = tck;
        s_next.tckSync = s_reg.tckMeta;
        s_next.tckPrev = s_reg.tckSync;
        s_next.tmsMeta = tms;
        s_next.tmsSync = s_reg.tmsMeta;
        s_next.tdiMeta = tdi;
        s_next.tdiSync = s_reg.tdiMeta;
        s_next.trstMeta = testResetN;
        s_next.trstSync = s_reg.trstMeta;
        s_next.padMeta = padIn;
        s_next.padSync = s_reg.padMeta;

        tckRise = s_reg.tckSync && !s_reg.tckPrev;
        tckFall = !s_reg.tckSync && s_reg.tckPrev;

        // Shared serial output picks one parallel path
        if (chainSelected(s_reg.irCur)) begin
            drBit = s_reg.bsShift[0];
        end else if (s_reg.irCur == `IR_IDCODE) begin
            drBit = s_reg.idShift[0];
        end else begin
            drBit = s_reg.bypass;
        end

        if (!s_reg.trstSync) begin
            s_next.tap = TEST_RESET;
            s_next.irCur = `IR_IDCODE;
            s_next.tdoOeN = 1'b1;
        end else if (tckRise) begin
            s_next.tap = tapNext(s_reg.tap, s_reg.tmsSync);
            if (s_reg.tap == CAPTURE_DR) begin
                s_next.bypass = 1'b0;
                s_next.idShift = ID_VALUE;
                if (chainSelected(s_reg.irCur)) begin
                    s_next.bsShift = captureChain(s_reg.padSync, coreOut, extestActive(s_reg.irCur));
                end
            end
            if (s_reg.tap == SHIFT_DR) begin
                s_next.bypass = s_reg.tdiSync;
                s_next.idShift = {s_reg.tdiSync, s_reg.idShift[`ID_WIDTH-1:1]};
                if (chainSelected(s_reg.irCur)) begin
                    s_next.bsShift = {s_reg.tdiSync, s_reg.bsShift[`BSC_LEN-1:1]};
                end
            end
            if (s_reg.tap == CAPTURE_IR) begin
                s_next.irShift = `IR_CAPTURE;
            end
            if (s_reg.tap == SHIFT_IR) begin
                s_next.irShift = {s_reg.tdiSync, s_reg.irShift[`IR_WIDTH-1:1]};
            end
        end else if (tckFall) begin
            if (s_reg.tap == UPDATE_IR) begin
                s_next.irCur = s_reg.irShift;
            end
            // Falling-edge update keeps skew off the latched data
            if (s_reg.tap == UPDATE_DR && chainSelected(s_reg.irCur)) begin
                s_next.bsLatch = s_reg.bsShift;
            end
            if (s_reg.tap == TEST_RESET) begin
                s_next.irCur = `IR_IDCODE;
            end
            if (s_reg.tap == SHIFT_DR) begin
                s_next.tdo = drBit;
                s_next.tdoOeN = 1'b0;
            end else if (s_reg.tap == SHIFT_IR) begin
                s_next.tdo = s_reg.irShift[0];
                s_next.tdoOeN = 1'b0;
            end else begin
                s_next.tdoOeN = 1'b1;
            end
        end

        // Pin drive follows the new instruction in the same update
        pinsFromLatch = latchDrivesPins(s_next.irCur);
        for (int k = 0; k < `BSC_LANES; k++) begin
            if (pinsFromLatch) begin
                s_next.pads.laneTransmitEnable[k] = s_next.bsLatch[`BSC_TX_CTL_BASE + k];
            end else if (pinsFloat(s_next.irCur)) begin
                s_next.pads.laneTransmitEnable[k] = 1'b0;
            end else begin
                s_next.pads.laneTransmitEnable[k] = coreOut.laneTransmitEnable[k];
            end
        end
        for (int k = 0; k < `BSC_BIDIR; k++) begin
            if (pinsFromLatch) begin
                s_next.pads.bidirOeN[k] = !s_next.bsLatch[`BSC_BIDIR_BASE + 2 * k];
                s_next.pads.bidirOut[k] = s_next.bsLatch[`BSC_BIDIR_BASE + 2 * k + 1];
            end else if (pinsFloat(s_next.irCur)) begin
                s_next.pads.bidirOeN[k] = 1'b1;
                s_next.pads.bidirOut[k] = coreOut.bidirOut[k];
            end else begin
                s_next.pads.bidirOeN[k] = !coreOut.bidirOutEnable[k];
                s_next.pads.bidirOut[k] = coreOut.bidirOut[k];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign tdo = s_reg.tdo;
    assign tdoOeN = s_reg.tdoOeN;
    assign padOut = s_reg.pads;

endmodule // boundary_scan_data_registers

/* File: boundary_scan_data_registers_checker.sv */
`timescale 1ns/1ps
`include "boundary_scan_defines.svh"
module boundary_scan_data_registers_checker
    import boundary_scan_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic testResetN,
    input wire logic tdo,
    input wire logic tdoOeN,
    // System pins
    input wire pad_in_type padIn,
    input wire core_out_type coreOut,
    input wire pad_out_type padOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck))
        else $error("serial output moved while test clock high");
    a_tdo_high_stable: assert property (tck [*2] |-> $stable(tdo))
        else $error("serial output moved in a high phase");
    a_oe_on_fall: assert property ($changed(tdoOeN) |-> !$past(tck) && !$past(tck, 2))
        else $error("serial enable moved outside a low phase");
    a_reset_oe_quiet: assert property ($fell(rst) |-> tdoOeN [*4])
        else $error("serial output enabled right after reset");
    a_reset_pins: assert property ($fell(rst) |-> padOut.bidirOeN == {`BSC_BIDIR{1'b1}} && !padOut.laneTransmitEnable)
        else $error("pins not released by reset");
    a_trst_bidir_pass: assert property (!testResetN [*5] |=>
        padOut.bidirOeN == ~$past(coreOut.bidirOutEnable) && padOut.bidirOut == $past(coreOut.bidirOut))
        else $error("bidir pins not following core under test reset");
    a_trst_lane_pass: assert property (!testResetN [*5] ##1 !testResetN |->
        padOut.laneTransmitEnable == $past(coreOut.laneTransmitEnable))
        else $error("lane enables not following core under test reset");
    a_input_no_effect: assert property (!testResetN [*5] ##0 $stable(coreOut) |=> $stable(padOut))
        else $error("pin inputs altered the output path");
endmodule // boundary_scan_data_registers_checker

bind boundary_scan_data_registers boundary_scan_data_registers_checker u_checker (.clk(clk), .rst(rst),
    .tck(tck), .tms(tms), .tdi(tdi), .testResetN(testResetN), .tdo(tdo), .tdoOeN(tdoOeN),
    .padIn(padIn), .coreOut(coreOut), .padOut(padOut));

/* File: scan_tester_model.sv */
`timescale 1ns/1ps
module scan_tester_model (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdoOeN
);
    // Test clock stands low between frames; pull-ups idle mode and data high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // Set while low, take output just before the fall
    task automatic step(input logic m, input logic d, output logic q, output logic e);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        #40 q = tdo;
        e = tdoOeN;
        tck = 1'b0;
    endtask

    task automatic reset_tap();
        logic q;
        logic e;
        repeat (5) step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
    endtask

    // From idle through one scan back to idle; odd offset keeps phase off the system clock
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout,
                        output logic ok);
        logic q;
        logic e;
        dout = 64'h0;
        ok = 1'b1;
        #3.3;
        step(1'b1, 1'b1, q, e);
        if (ir) step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q, e);
            dout[i] = q;
            ok &= !e;
        end
        step(1'b1, 1'b1, q, e);
        step(1'b0, 1'b1, q, e);
        tdi = 1'b1;
        #6.7;
    endtask
endmodule // scan_tester_model

/* File: boundary_scan_data_registers_tb.sv */
`timescale 1ns/1ps
`include "boundary_scan_defines.svh"
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end
module boundary_scan_data_registers_tb import boundary_scan_pkg::*;;
    localparam logic [31:0] ID = 32'h0000_0003; // Arbitrary value, bit 0 kept high
    localparam logic [63:0] PAT = 64'hC3A5_96F0_1E2D_4B78;
    localparam logic [42:0] P = 43'h0A5_5C3C_96E1;
    typedef struct packed {logic [5:0] code; logic [6:0] len; logic [1:0] mode;} row_type;
    // ****
    // Ordinary cases: mode 0 pass-through, 1 high-z, 2 pins not checked
    // ****
    row_type rows [8] = '{'{`IR_BYPASS, 7'd1, 2'd0}, '{`IR_HIGHZ, 7'd1, 2'd1}, '{`IR_CLAMP, 7'd1, 2'd2},
        '{6'h04, 7'd1, 2'd0}, '{`IR_CAPTURE, 7'd1, 2'd0}, '{`IR_IDCODE, 7'd32, 2'd0},
        '{`IR_SAMPLE, 7'd43, 2'd0}, '{`IR_EXTEST, 7'd43, 2'd2}};
    logic clk = 1'b0;
    logic rst;
    logic testResetN;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdoOeN;
    pad_in_type padIn;
    core_out_type coreOut;
    pad_out_type padOut;
    int n_errors = 0;
    int comparisons = 0;
    logic [63:0] o;
    logic ok;

    always #5 clk = ~clk;

    boundary_scan_data_registers #(.ID_VALUE(ID)) u_boundary_scan_data_registers (.clk(clk), .rst(rst),
        .tck(tck), .tms(tms), .tdi(tdi), .testResetN(testResetN), .tdo(tdo), .tdoOeN(tdoOeN),
        .padIn(padIn), .coreOut(coreOut), .padOut(padOut));
    scan_tester_model u_scan_tester_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN));

    // Expected capture from the cell map
    function automatic logic [42:0] chain(input logic ext);
        logic [42:0] c;
        c[14:0] = {padIn.fundamentalResetN, padIn.upstreamCommonClockStrap, padIn.downstreamCommonClockStrap,
            padIn.laneReceivePositive, padIn.laneReceiveNegative};
        c[20:15] = coreOut.laneTransmitEnable;
        for (int k = 0; k < 11; k++) begin
            c[`BSC_BIDIR_BASE + 2 * k] = coreOut.bidirOutEnable[k];
            c[`BSC_BIDIR_BASE + 2 * k + 1] = (!ext && coreOut.bidirOutEnable[k]) ? coreOut.bidirOut[k]
                : padIn.bidirIn[k];
        end
        return c;
    endfunction

    // Pins driven from update latches
    function automatic pad_out_type pins(input logic [42:0] c);
        pad_out_type p;
        p.laneTransmitEnable = c[20:15];
        for (int k = 0; k < 11; k++) begin
            p.bidirOeN[k] = ~c[`BSC_BIDIR_BASE + 2 * k];
            p.bidirOut[k] = c[`BSC_BIDIR_BASE + 2 * k + 1];
        end
        return p;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        n_errors++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        testResetN = 1'b1;
        padIn = '{6'h2D, 6'h13, 1'b1, 1'b0, 1'b1, 11'h1F0};
        coreOut = '{6'h2A, 11'h3C3, 11'h5A5};
        tick(16);
        rst = 1'b0;
        tick(6);
        u_scan_tester_model.reset_tap();
        for (int r = 0; r < 8; r++) begin
            u_scan_tester_model.scan(1'b1, 6, {58'h0, rows[r].code}, o, ok);
            `CHECK(o[5:0], 6'h2D)
            u_scan_tester_model.scan(1'b0, 64, PAT, o, ok);
            `CHECK(o >> rows[r].len, (PAT << rows[r].len) >> rows[r].len)
            `CHECK(ok, 1'b1)
            if (rows[r].len == 1) `CHECK(o[0], 1'b0)
            if (rows[r].len == 32) `CHECK(o[31:0], ID)
            if (rows[r].mode == 0) `CHECK(padOut.bidirOeN, ~coreOut.bidirOutEnable)
            if (rows[r].mode == 1) `CHECK({padOut.laneTransmitEnable, padOut.bidirOeN}, 17'h0_07FF)
        end
        // Safe values preloaded before the pins are handed over
        u_scan_tester_model.scan(1'b1, 6, 64'h1, o, ok);
        u_scan_tester_model.scan(1'b0, 43, {21'h0, P}, o, ok);
        `CHECK(o[42:0], chain(1'b0))
        `CHECK(padOut.bidirOut, coreOut.bidirOut)
        u_scan_tester_model.scan(1'b1, 6, 64'h0, o, ok);
        `CHECK(padOut, pins(P))
        u_scan_tester_model.scan(1'b0, 43, {21'h0, ~P}, o, ok);
        `CHECK(o[42:0], chain(1'b1))
        `CHECK(padOut, pins(~P))
        // Test reset in mid EXTEST hands pins back to the core
        testResetN = 1'b0;
        tick(8);
        padIn.bidirIn = 11'h70F;
        tick(4);
        coreOut.bidirOut = 11'h0F1;
        tick(3);
        `CHECK(padOut.bidirOut, coreOut.bidirOut)
        testResetN = 1'b1;
        tick(4);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(6);
        `CHECK(tdoOeN, 1'b1)
        give_verdict();
    end
endmodule // boundary_scan_data_registers_tb
